// [ial_top.sv]
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module ial_top
  import ial_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt sources
  input wire logic nm_pin,
  input wire logic wdt_overflow,
  input wire logic [NSRC-1:0] src_req,
  // CPU sequencer
  input wire logic instr_boundary,
  input wire logic return_from_irq_op,
  input wire logic bank_switch_return_op,
  input wire logic ie_restore,
  input wire logic ie_restore_val,
  input wire logic [7:0] vec_even_byte,
  output logic push_status_word,
  output logic push_program_counter,
  output logic bank_save,
  output logic [2:0] bank_sel,
  output logic load_program_counter,
  output logic [VEC_W-1:0] entry_vector,
  output logic macro_req,
  output logic [SRC_W-1:0] macro_src,
  output logic global_irq_enable,
  output logic [7:0] in_service_level_register
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [7:0] top_isr_bit(input logic [7:0] isr, input logic rank);
    logic [7:0] m;
    m = '0;
    if (rank && isr[ISR_WDT_BIT]) begin
      m[ISR_WDT_BIT] = 1'b1;
    end else if (isr[ISR_PIN_BIT]) begin
      m[ISR_PIN_BIT] = 1'b1;
    end else if (isr[ISR_WDT_BIT]) begin
      m[ISR_WDT_BIT] = 1'b1;
    end else if (isr[0]) begin
      m[0] = 1'b1;
    end else if (isr[1]) begin
      m[1] = 1'b1;
    end else if (isr[2]) begin
      m[2] = 1'b1;
    end else if (isr[3]) begin
      m[3] = 1'b1;
    end
    return m;
  endfunction

  function automatic logic level_ok(input logic [7:0] isr, input logic nest,
                                    input logic [1:0] lvl);
    logic ok;
    ok = !isr[ISR_PIN_BIT] && !isr[ISR_WDT_BIT];
    if (isr[0]) begin
      ok = 1'b0;
    end else if (isr[1]) begin
      ok = ok && (lvl < 2'h1);
    end else if (isr[2]) begin
      ok = ok && (lvl < 2'h2);
    end else if (isr[3] && nest) begin
      ok = ok && (lvl < 2'h3);
    end
    return ok;
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] wdm_r;
  logic [7:0] imc_r;
  logic ie_r;
  logic [7:0] isr_r;
  logic pin_prev_r;
  logic pin_pend_r;
  logic wdt_pend_r;
  logic [NSRC-1:0] req_r;
  logic [NSRC-1:0] mask_r;
  logic [NSRC-1:0] macro_r;
  logic [NSRC-1:0] ctx_r;
  logic [2*NSRC-1:0] prio_r;
  ial_state_t state_r;
  ial_state_t state_nxt;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic push_sw_r;
  logic push_pc_r;
  logic bank_save_r;
  logic [2:0] bank_sel_r;
  logic load_pc_r;
  logic [VEC_W-1:0] vec_r;
  logic macro_req_r;
  logic [SRC_W-1:0] macro_src_r;

  // ****************************************
  // APB decode
  // ****************************************
  wire access = psel && penable && !pready_r;
  wire wr_en = psel && penable && pready_r && pwrite;
  wire is_src = (paddr >= OFS_SRC_BASE) && (paddr <= OFS_SRC_LAST) && (paddr[1:0] == 2'h0);
  wire [SRC_W-1:0] src_ix = paddr[SRC_W+1:2];
  wire hit_wdm = paddr == OFS_WDOG_MODE;
  wire hit_imc = paddr == OFS_IRQ_MODE;
  wire hit_ie = paddr == OFS_GLOBAL_EN;
  wire hit_isr = paddr == OFS_IN_SERVICE;
  wire hit_pend = paddr == OFS_NM_PENDING;
  wire mapped = hit_wdm || hit_imc || hit_ie || hit_isr || hit_pend || is_src;
  wire [7:0] src_rd = {req_r[src_ix], mask_r[src_ix], 2'h0, ctx_r[src_ix],
                       macro_r[src_ix], prio_r[2*src_ix +: 2]};
  wire [7:0] rd_byte = hit_wdm ? wdm_r :
                       hit_imc ? imc_r :
                       hit_ie ? {7'h00, ie_r} :
                       hit_isr ? isr_r :
                       hit_pend ? {6'h00, wdt_pend_r, pin_pend_r} :
                       is_src ? src_rd : 8'h00;

  // ****************************************
  // Non-maskable arbitration
  // ****************************************
  wire rank = wdm_r[WDM_RANK_BIT];
  wire pin_edge = nm_pin && !pin_prev_r;
  wire pin_block = isr_r[ISR_PIN_BIT] || (rank && isr_r[ISR_WDT_BIT]);
  wire wdt_block = isr_r[ISR_WDT_BIT] || (!rank && isr_r[ISR_PIN_BIT]);
  wire pin_can = pin_pend_r && !pin_block;
  wire wdt_can = wdt_pend_r && !wdt_block;
  wire pin_wins = pin_can && !(rank && wdt_can);
  wire at_boundary = instr_boundary && (state_r == ST_IDLE);
  wire take_pin = at_boundary && pin_wins;
  wire take_wdt = at_boundary && wdt_can && !pin_wins;
  wire take_nm = take_pin || take_wdt;

  // ****************************************
  // Maskable arbitration
  // ****************************************
  logic [NSRC-1:0] cand;
  logic win_valid;
  logic [SRC_W-1:0] win_idx;

  generate
    for (genvar g = 0; g < NSRC; g++) begin : g_cand
      wire elig = req_r[g] && !mask_r[g];
      assign cand[g] = elig && (macro_r[g] ||
        (ie_r && level_ok(isr_r, imc_r[IMC_NEST_BIT], prio_r[2*g +: 2])));
    end
  endgenerate

  ial_arbiter u_arb (
    .cand(cand),
    .prio(prio_r),
    .win_valid(win_valid),
    .win_idx(win_idx)
  );

  wire take_mask = at_boundary && !take_nm && win_valid;
  wire win_macro = macro_r[win_idx];
  wire take_vec = take_mask && !win_macro;
  wire take_macro = take_mask && win_macro;
  wire [1:0] win_lvl = prio_r[2*win_idx +: 2];
  wire do_return = return_from_irq_op || bank_switch_return_op;

  // ****************************************
  // Entry sequencer
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (take_nm) begin
          state_nxt = ST_PUSH_SW;
        end else if (take_vec && ctx_r[win_idx]) begin
          state_nxt = ST_CTX;
        end else if (take_vec) begin
          state_nxt = ST_PUSH_SW;
        end
      end
      ST_PUSH_SW: state_nxt = ST_PUSH_PC;
      ST_PUSH_PC: state_nxt = ST_BRANCH;
      ST_CTX: state_nxt = ST_BRANCH;
      ST_BRANCH: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      push_sw_r <= 1'b0;
      push_pc_r <= 1'b0;
      bank_save_r <= 1'b0;
      load_pc_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      push_sw_r <= state_nxt == ST_PUSH_SW;
      push_pc_r <= state_nxt == ST_PUSH_PC;
      bank_save_r <= state_nxt == ST_CTX;
      load_pc_r <= state_nxt == ST_BRANCH;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_r <= VEC_PIN;
      bank_sel_r <= 3'h0;
      macro_req_r <= 1'b0;
      macro_src_r <= '0;
    end else begin
      macro_req_r <= take_macro;
      if (take_macro) begin
        macro_src_r <= win_idx;
      end
      if (take_nm) begin
        vec_r <= take_pin ? VEC_PIN : VEC_WDT;
      end else if (take_vec) begin
        vec_r <= VEC_SRC0 + VEC_W'(win_idx);
      end
      if (state_r == ST_CTX) begin
        bank_sel_r <= vec_even_byte[2:0];
      end
    end
  end

  // ****************************************
  // Non-maskable pending flags
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_r <= 1'b0;
      pin_pend_r <= 1'b0;
      wdt_pend_r <= 1'b0;
    end else begin
      pin_prev_r <= nm_pin;
      pin_pend_r <= pin_edge || (pin_pend_r && !take_pin);
      wdt_pend_r <= wdt_overflow || (wdt_pend_r && !take_wdt);
    end
  end

  // ****************************************
  // In-service register and global enable
  // ****************************************
  wire [7:0] isr_clr = do_return ? top_isr_bit(isr_r, rank) : 8'h00;
  wire [7:0] isr_set = take_pin ? (8'h01 << ISR_PIN_BIT) :
                       take_wdt ? (8'h01 << ISR_WDT_BIT) :
                       take_vec ? (8'h01 << win_lvl) : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      isr_r <= ISR_RESET;
      ie_r <= 1'b0;
    end else begin
      isr_r <= (isr_r & ~isr_clr) | isr_set;
      if (take_nm || take_vec) begin
        ie_r <= 1'b0;
      end else if (ie_restore) begin
        ie_r <= ie_restore_val;
      end else if (wr_en && hit_ie) begin
        ie_r <= pwdata[0];
      end
    end
  end

  // ****************************************
  // Mode registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdm_r <= WDM_RESET;
      imc_r <= IMC_RESET;
    end else begin
      if (wr_en && hit_wdm) begin
        wdm_r <= pwdata[7:0];
      end
      if (wr_en && hit_imc) begin
        imc_r <= pwdata[7:0] & (8'h01 << IMC_NEST_BIT);
      end
    end
  end

  // ****************************************
  // Per-source control
  // ****************************************
  generate
    for (genvar s = 0; s < NSRC; s++) begin : g_src
      wire wr_s = wr_en && is_src && (src_ix == SRC_W'(s));
      wire acc_s = take_mask && (win_idx == SRC_W'(s));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          req_r[s] <= 1'b0;
          mask_r[s] <= 1'b1;
          macro_r[s] <= 1'b0;
          ctx_r[s] <= 1'b0;
          prio_r[2*s +: 2] <= PRIO_RESET;
        end else begin
          if (src_req[s]) begin
            req_r[s] <= 1'b1;
          end else if (wr_s) begin
            req_r[s] <= pwdata[SC_REQ_BIT];
          end else if (acc_s) begin
            req_r[s] <= 1'b0;
          end
          if (wr_s) begin
            mask_r[s] <= pwdata[SC_MASK_BIT];
            macro_r[s] <= pwdata[SC_MACRO_BIT];
            ctx_r[s] <= pwdata[SC_CTX_BIT];
            prio_r[2*s +: 2] <= pwdata[SC_PRIO_LO +: 2];
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // APB answer, one wait state
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= access;
      pslverr_r <= access && !mapped;
      prdata_r <= (access && !pwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign push_status_word = push_sw_r;
  assign push_program_counter = push_pc_r;
  assign bank_save = bank_save_r;
  assign bank_sel = bank_sel_r;
  assign load_program_counter = load_pc_r;
  assign entry_vector = vec_r;
  assign macro_req = macro_req_r;
  assign macro_src = macro_src_r;
  assign global_irq_enable = ie_r;
  assign in_service_level_register = isr_r;

endmodule
`default_nettype wire

// [ial_pkg.sv]
package ial_pkg;

  localparam int NSRC = 8;
  localparam int SRC_W = 3;
  localparam int VEC_W = 4;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [11:0] OFS_WDOG_MODE = 12'h000;
  localparam logic [11:0] OFS_IRQ_MODE = 12'h004;
  localparam logic [11:0] OFS_GLOBAL_EN = 12'h008;
  localparam logic [11:0] OFS_IN_SERVICE = 12'h00c;
  localparam logic [11:0] OFS_NM_PENDING = 12'h010;
  localparam logic [11:0] OFS_SRC_BASE = 12'h040;
  localparam logic [11:0] OFS_SRC_LAST = 12'h05c;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int WDM_RANK_BIT = 4;
  localparam int IMC_NEST_BIT = 7;
  localparam int ISR_PIN_BIT = 7;
  localparam int ISR_WDT_BIT = 6;
  localparam int SC_PRIO_LO = 0;
  localparam int SC_MACRO_BIT = 2;
  localparam int SC_CTX_BIT = 3;
  localparam int SC_MASK_BIT = 6;
  localparam int SC_REQ_BIT = 7;
  localparam logic [7:0] WDM_RESET = 8'h00;
  localparam logic [7:0] IMC_RESET = 8'h80;
  localparam logic [7:0] ISR_RESET = 8'h00;
  localparam logic [1:0] PRIO_RESET = 2'h3;

  // ****************************************
  // Entry vector codes
  // ****************************************
  localparam logic [VEC_W-1:0] VEC_PIN = 4'h0;
  localparam logic [VEC_W-1:0] VEC_WDT = 4'h1;
  localparam logic [VEC_W-1:0] VEC_SRC0 = 4'h8;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_PUSH_SW = 5'b00010,
    ST_PUSH_PC = 5'b00100,
    ST_CTX = 5'b01000,
    ST_BRANCH = 5'b10000
  } ial_state_t;

endpackage

// [ial_arbiter.sv]
`timescale 1ns/10ps
`default_nettype none
module ial_arbiter
  import ial_pkg::*;
(
  // Candidates
  input wire logic [NSRC-1:0] cand,
  input wire logic [2*NSRC-1:0] prio,
  // Winner
  output logic win_valid,
  output logic [SRC_W-1:0] win_idx
);

  logic [1:0] best;

  // ****************************************
  // Lowest level number wins, lower index breaks ties
  // ****************************************
  always_comb begin
    win_valid = 1'b0;
    win_idx = '0;
    best = 2'h3;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (cand[i] && (!win_valid || prio[2*i +: 2] <= best)) begin
        win_valid = 1'b1;
        win_idx = SRC_W'(i);
        best = prio[2*i +: 2];
      end
    end
  end

endmodule
`default_nettype wire

// [ial_top_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module ial_top_assertions
  import ial_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Interrupt sources
  input wire logic nm_pin,
  input wire logic wdt_overflow,
  input wire logic [NSRC-1:0] src_req,
  // CPU sequencer
  input wire logic instr_boundary,
  input wire logic return_from_irq_op,
  input wire logic bank_switch_return_op,
  input wire logic ie_restore,
  input wire logic ie_restore_val,
  input wire logic [7:0] vec_even_byte,
  input wire logic push_status_word,
  input wire logic push_program_counter,
  input wire logic bank_save,
  input wire logic [2:0] bank_sel,
  input wire logic load_program_counter,
  input wire logic [VEC_W-1:0] entry_vector,
  input wire logic macro_req,
  input wire logic [SRC_W-1:0] macro_src,
  input wire logic global_irq_enable,
  input wire logic [7:0] in_service_level_register
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one cycle after access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_entry_order: assert property (push_status_word |=> push_program_counter ##1 load_program_counter)
    else $error("entry push order broken");
  a_entry_disable: assert property (push_status_word || bank_save |-> !global_irq_enable)
    else $error("enable not cleared on entry");
  a_pin_isr_bit: assert property (push_status_word && entry_vector == VEC_PIN |-> in_service_level_register[ISR_PIN_BIT])
    else $error("pin in-service bit missing");
  a_wdt_isr_bit: assert property (push_status_word && entry_vector == VEC_WDT |-> in_service_level_register[ISR_WDT_BIT])
    else $error("watchdog in-service bit missing");
  a_ctx_bank_path: assert property (bank_save |=> load_program_counter && !push_program_counter && bank_sel == $past(vec_even_byte[2:0]))
    else $error("context entry bank or branch wrong");
  a_vec_gate: assert property (push_status_word && entry_vector >= VEC_SRC0 |-> $past(global_irq_enable) && $past(in_service_level_register[7:6]) == 2'h0)
    else $error("maskable entry while blocked");
  a_isr_reset: assert property ($rose(presetn) |-> in_service_level_register == ISR_RESET)
    else $error("in-service not cleared by reset");
  a_ret_clear: assert property ((return_from_irq_op || bank_switch_return_op) && $onehot(in_service_level_register) && !push_status_word && !bank_save |=> in_service_level_register == 8'h00 || push_status_word || bank_save)
    else $error("return did not clear in-service bit");

  c_wdt_entry: cover property (push_status_word && entry_vector == VEC_WDT);
  c_ctx_entry: cover property (bank_save);
  c_macro: cover property (macro_req);
  c_slverr: cover property (pslverr);
endmodule

bind ial_top ial_top_assertions u_ial_top_assertions (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .nm_pin, .wdt_overflow, .src_req, .instr_boundary, .return_from_irq_op,
  .bank_switch_return_op, .ie_restore, .ie_restore_val, .vec_even_byte, .push_status_word,
  .push_program_counter, .bank_save, .bank_sel, .load_program_counter, .entry_vector,
  .macro_req, .macro_src, .global_irq_enable, .in_service_level_register
);
`default_nettype wire

// [ial_cpu_model.sv]
`timescale 1ns/10ps
`default_nettype none
module ial_cpu_model
  import ial_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pace
  input wire logic slow,
  // Sequencer
  output logic instr_boundary
);
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;

  assign cnt_nxt = (cnt_r == 2'h2) ? 2'h0 : cnt_r + 2'h1;
  // Boundary each cycle, or every third when slow
  assign instr_boundary = slow ? (cnt_r == 2'h2) : 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_r <= 2'h0;
    else cnt_r <= cnt_nxt;
  end
endmodule
`default_nettype wire

// [interrupt_acknowledge_logic_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module interrupt_acknowledge_logic_bench
  import ial_pkg::*;
  ;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic nm_pin = 1'b0;
  logic wdt_overflow = 1'b0;
  logic [NSRC-1:0] src_req = 8'h00;
  logic slow = 1'b0;
  logic return_from_irq_op = 1'b0;
  logic bank_switch_return_op = 1'b0;
  logic ie_restore = 1'b0;
  logic ie_restore_val = 1'b0;
  logic [7:0] vec_even_byte = 8'h00;
  logic [31:0] prdata;
  logic pready, pslverr, instr_boundary, push_status_word, push_program_counter;
  logic bank_save, load_program_counter, macro_req, global_irq_enable;
  logic [2:0] bank_sel;
  logic [VEC_W-1:0] entry_vector;
  logic [SRC_W-1:0] macro_src;
  logic [7:0] in_service_level_register;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  logic [15:0] qe[$];
  logic [2:0] qm[$];
  logic [1:0] lv[8];

  initial begin
    forever #50 pclk = ~pclk;
  end

  ial_top u_ial_top (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .nm_pin, .wdt_overflow, .src_req, .instr_boundary, .return_from_irq_op,
    .bank_switch_return_op, .ie_restore, .ie_restore_val, .vec_even_byte, .push_status_word,
    .push_program_counter, .bank_save, .bank_sel, .load_program_counter, .entry_vector,
    .macro_req, .macro_src, .global_irq_enable, .in_service_level_register
  );

  ial_cpu_model u_ial_cpu_model (.pclk, .presetn, .slow, .instr_boundary);

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic summarize;
    if (bad_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk("prdata", x, r);
    chk("pslverr", {31'h0, xe}, {31'h0, e});
  endtask

  task automatic ev(input int k, input logic [7:0] m);
    @(posedge pclk);
    nm_pin <= (k == 0);
    wdt_overflow <= (k == 1);
    src_req <= (k == 2) ? m : 8'h00;
    return_from_irq_op <= (k == 3);
    bank_switch_return_op <= (k == 4);
    ie_restore <= (k > 2);
    ie_restore_val <= m[0];
    @(posedge pclk);
    {nm_pin, wdt_overflow, return_from_irq_op, bank_switch_return_op, ie_restore} <= 5'h00;
    src_req <= 8'h00;
  endtask

  task automatic wq(input int n);
    int t = 0;
    while (qe.size() + qm.size() > n && t < 300) begin
      @(posedge pclk);
      t++;
    end
  endtask

  // ****************************************
  // Monitor and timeout
  // ****************************************
  always @(negedge pclk) begin
    logic [15:0] n;
    if (presetn && load_program_counter === 1'b1) begin
      chk("entry_noted", 32'h1, {31'h0, qe.size() > 0});
      if (qe.size() > 0) begin
        n = qe.pop_front();
        chk("entry_vector", n[3:0], entry_vector);
        chk("in_service", n[11:4], in_service_level_register);
        chk("irq_enable", 32'h0, {31'h0, global_irq_enable});
        if (n[15]) chk("bank_sel", n[14:12], bank_sel);
      end
    end
    if (presetn && macro_req === 1'b1) begin
      chk("macro_noted", 32'h1, {31'h0, qm.size() > 0});
      if (qm.size() > 0) chk("macro_src", qm.pop_front(), macro_src);
    end
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int i, k, b;
    logic [31:0] r;
    logic [7:0] dn;
    r = $urandom(32'h7a60);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rchk(OFS_WDOG_MODE, {24'h0, WDM_RESET}, 1'b0);
    rchk(OFS_IRQ_MODE, {24'h0, IMC_RESET}, 1'b0);
    rchk(OFS_GLOBAL_EN, 32'h0, 1'b0);
    wr(OFS_IN_SERVICE, 32'hff);
    rchk(OFS_IN_SERVICE, {24'h0, ISR_RESET}, 1'b0);
    rchk(OFS_SRC_BASE, 32'h43, 1'b0);
    rchk(12'h020, 32'h0, 1'b1);
    qe.push_back({4'h0, 8'h80, VEC_PIN});
    ev(0, 8'h00);
    wq(0);
    qe.push_back({4'h0, 8'h80, VEC_PIN});
    qe.push_back({4'h0, 8'h40, VEC_WDT});
    qm.push_back(3'h2);
    ev(0, 8'h00);
    ev(0, 8'h00);
    ev(1, 8'h00);
    rchk(OFS_NM_PENDING, 32'h3, 1'b0);
    wr(OFS_SRC_BASE + 12'h008, 32'h04);
    ev(2, 8'h04);
    wq(2);
    ev(3, 8'h00);
    wq(1);
    ev(3, 8'h00);
    wq(0);
    ev(3, 8'h00);
    wr(OFS_WDOG_MODE, 32'h10);
    qe.push_back({4'h0, 8'h80, VEC_PIN});
    qe.push_back({4'h0, 8'hc0, VEC_WDT});
    ev(0, 8'h00);
    wq(1);
    ev(1, 8'h00);
    wq(0);
    ev(3, 8'h00);
    rchk(OFS_IN_SERVICE, 32'h80, 1'b0);
    ev(3, 8'h00);
    rchk(OFS_IN_SERVICE, 32'h00, 1'b0);
    r = $urandom;
    vec_even_byte <= r[7:0];
    wr(OFS_SRC_BASE, 32'h08);
    wr(OFS_GLOBAL_EN, 32'h1);
    qe.push_back({1'b1, r[2:0], 8'h01, VEC_SRC0});
    ev(2, 8'h01);
    wq(0);
    ev(4, 8'h01);
    rchk(OFS_IN_SERVICE, 32'h00, 1'b0);
    slow <= 1'b1;
    wr(OFS_SRC_BASE + 12'h01c, 32'h40);
    for (i = 0; i < 7; i++) begin
      r = $urandom;
      lv[i] = r[1:0];
      wr(OFS_SRC_BASE + 12'(4 * i), {30'h0, r[1:0]});
    end
    dn = 8'h00;
    for (k = 0; k < 7; k++) begin
      b = 7;
      for (i = 0; i < 7; i++) if (!dn[i] && (b == 7 || lv[i] < lv[b])) b = i;
      dn[b] = 1'b1;
      qe.push_back({4'h0, 8'h01 << lv[b], VEC_SRC0 + 4'(b)});
    end
    ev(2, 8'hff);
    for (k = 6; k >= 0; k--) begin
      wq(k);
      ev(3, 8'h01);
    end
    wr(OFS_GLOBAL_EN, 32'h0);
    wr(OFS_SRC_BASE + 12'h01c, 32'h83);
    qe.push_back({4'h0, 8'h08, VEC_SRC0 + 4'h7});
    wr(OFS_GLOBAL_EN, 32'h1);
    wq(0);
    wr(OFS_SRC_BASE + 12'h018, 32'h03);
    wr(OFS_GLOBAL_EN, 32'h1);
    ev(2, 8'h40);
    rchk(OFS_SRC_BASE + 12'h018, 32'h83, 1'b0);
    qe.push_back({4'h0, 8'h08, VEC_SRC0 + 4'h6});
    wr(OFS_IRQ_MODE, 32'h0);
    wq(0);
    ev(3, 8'h01);
    chk("notes_left", 32'h0, 32'(qe.size() + qm.size()));
    summarize();
  end
endmodule
`default_nettype wire
